// *** dv/bbcfg_host_model.sv ***
`timescale 1ns/1ps

// Register host: one-cycle strobes, scrambles lines once released
module bbcfg_host_model (
  input  wire logic       clk_in,
  input  wire logic [7:0] rd_data_in,
  output logic      [7:0] addr_out,
  output logic            wr_out,
  output logic      [7:0] wr_data_out,
  output logic            rd_out
);
  // Idle bus at time zero
  initial begin
    addr_out    = 8'h00;
    wr_out      = 1'b0;
    wr_data_out = 8'h00;
    rd_out      = 1'b0;
  end

  // Write one byte; callers keep to the power and result codes
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_out    <= a;
    wr_data_out <= d;
    wr_out      <= 1'b1;
    @(posedge clk_in);
    wr_out      <= 1'b0;
    addr_out    <= ~a; // Released lines show inverse
    wr_data_out <= ~d;
  endtask

  // Read one byte, answer sampled one edge after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_in);
    addr_out <= a;
    rd_out   <= 1'b1;
    @(posedge clk_in);
    rd_out   <= 1'b0;
    addr_out <= ~a;
    @(posedge clk_in);
    #1 d = rd_data_in;
  endtask
endmodule

// *** dv/billboard_config_register_tb.sv ***
`timescale 1ns/1ps

module billboard_config_register_tb;
  logic       sys_clk_in    = 1'b0;
  logic       rst_n_in      = 1'b0;
  logic       smbus_mode_in = 1'b0;
  logic [1:0] pins          = 2'h2;
  logic       attach        = 1'b1;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic [7:0] got;
  logic       wr;
  logic       rd;
  logic [3:0] pwr;
  logic [1:0] cfg;
  logic       req;
  logic       rsv;
  logic       ok;
  logic       fail;
  logic       conn;
  int         err_count     = 0;
  int         cmp_count     = 0;

  // 40 MHz clock
  always #12.5 sys_clk_in = ~sys_clk_in;

  bbcfg_register i_dut (
    .sys_clk_in              (sys_clk_in),
    .rst_n_in                (rst_n_in),
    .smbus_mode_in           (smbus_mode_in),
    .alt_mode_result_pins_in (pins),
    .billboard_attach_pin_in (attach),
    .reg_addr_in             (addr),
    .reg_wr_in               (wr),
    .reg_wr_data_in          (wdata),
    .reg_rd_in               (rd),
    .reg_rd_data_out         (rdata),
    .desc_vconn_power_out    (pwr),
    .desc_vconn_required_out (req),
    .desc_vconn_reserved_out (rsv),
    .desc_configured_out     (cfg),
    .desc_alt_mode_ok_out    (ok),
    .desc_failure_info_out   (fail),
    .billboard_connect_out   (conn)
  );

  bbcfg_host_model i_host (
    .clk_in      (sys_clk_in),
    .rd_data_in  (rdata),
    .addr_out    (addr),
    .wr_out      (wr),
    .wr_data_out (wdata),
    .rd_out      (rd)
  );

  // Verdict and end of run
  task automatic summarize();
    $display("errors %0d compares %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Byte compare
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("Error %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // All descriptor outputs for one field set
  task automatic chk_desc(input logic [3:0] p, input logic [1:0] c, input logic f,
                          input logic a);
    chk({pwr, cfg, fail, conn}, {p, c, f & ~p[3], a});
    chk({6'h00, req, rsv}, {6'h00, ~p[3], p == 4'h7});
    chk({7'h00, ok}, {7'h00, c == 2'h3});
  endtask

  // Hang guard
  initial begin
    #100000;
    err_count++;
    summarize();
  end

  // Main sequence
  initial begin
    logic [7:0] v;
    repeat (5) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    repeat (8) @(posedge sys_clk_in);
    i_host.rd(8'h2B, got);
    chk(got, 8'h89);
    chk_desc(4'h8, 2'h2, 1'b0, 1'b1);
    i_host.wr(8'h2B, 8'h76);
    i_host.rd(8'h2B, got);
    chk(got, 8'h89);
    chk_desc(4'h8, 2'h2, 1'b0, 1'b1);
    smbus_mode_in <= 1'b1;
    repeat (5) @(posedge sys_clk_in);
    // Every power code, result code, both fail and attach levels
    for (int i = 0; i < 16; i++) begin
      v = {i[3:0], i[1:0], ~i[2], i[0]};
      i_host.wr(8'h2B, v);
      i_host.rd(8'h2B, got);
      chk(got, v);
      chk_desc(i[3:0], i[1:0], ~i[2], i[0]);
    end
    // Unmapped address, register keeps the last loop value
    i_host.wr(8'h2C, 8'h00);
    i_host.rd(8'h2C, got);
    chk(got, 8'h00);
    i_host.rd(8'h2B, got);
    chk(got, 8'hFD);
    // Back to strap mode with new pin levels
    smbus_mode_in <= 1'b0;
    pins          <= 2'h1;
    attach        <= 1'b0;
    repeat (5) @(posedge sys_clk_in);
    i_host.rd(8'h2B, got);
    chk(got, 8'h84);
    chk_desc(4'h8, 2'h1, 1'b0, 1'b0);
    summarize();
  end
endmodule

// *** include/bbcfg_pkg.sv ***
package bbcfg_pkg;

  // Register location and width
  localparam logic [7:0] BBCFG_OFFSET    = 8'h2B;
  localparam int         BBCFG_WIDTH     = 8;

  // Value after reset of the stored register and of read data
  localparam logic [7:0] BBCFG_RESET     = 8'h00;
  localparam logic [7:0] BBCFG_RD_IDLE   = 8'h00;

  // Field positions
  localparam int VCONN_MSB    = 7;
  localparam int VCONN_LSB    = 4;
  localparam int ALT_MSB      = 3;
  localparam int ALT_LSB      = 2;
  localparam int FAIL_POS     = 1;
  localparam int ATTACH_POS   = 0;

  // Fixed field values while in I2C mode
  localparam logic [3:0] VCONN_I2C_FIXED = 4'h8;
  localparam logic       FAIL_I2C_FIXED  = 1'b0;

  // Power need encoding
  localparam logic [3:0] VCONN_RESERVED  = 4'h7;

  // Alternate mode result encoding
  typedef enum logic [1:0] {
    ALT_UNSPEC_ERR    = 2'h0,
    ALT_NOT_TRIED     = 2'h1,
    ALT_TRIED_FAILED  = 2'h2,
    ALT_CONFIGURED_OK = 2'h3
  } bbcfg_alt_type;

  // Synchroniser depth
  localparam int SYNC_STAGES = 2;

endpackage

// *** logic/bbcfg_register.sv ***
`timescale 1ns/1ps

// Function
// - SMBus mode: power need field is writable and reads back as written.
// - I2C mode: power need field is read-only and reads 1000b.
// - Current power need value drives the descriptor power field.
// - Power codes 0000b..0110b are 1..6 W, 0111b reserved, 1xxxb none.
// - SMBus mode: alternate mode result is writable and drives descriptor.
// - I2C mode: alternate mode result is read-only and follows strap pins.
// - Result codes: 00 error, 01 not tried, 10 failed, 11 configured.
// - Failure info bit is ignored while the power field top bit is set.
// - SMBus mode: written failure info bit goes to the descriptor.
// - I2C mode: failure info bit is read-only and held at zero.
module bbcfg_register (
  input  wire logic       sys_clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       smbus_mode_in,
  input  wire logic [1:0] alt_mode_result_pins_in,
  input  wire logic       billboard_attach_pin_in,
  input  wire logic [7:0] reg_addr_in,
  input  wire logic       reg_wr_in,
  input  wire logic [7:0] reg_wr_data_in,
  input  wire logic       reg_rd_in,
  output logic      [7:0] reg_rd_data_out,
  output logic      [3:0] desc_vconn_power_out,
  output logic            desc_vconn_required_out,
  output logic            desc_vconn_reserved_out,
  output logic      [1:0] desc_configured_out,
  output logic            desc_alt_mode_ok_out,
  output logic            desc_failure_info_out,
  output logic            billboard_connect_out
);

  // Effective register view for the current mode
  function automatic logic [7:0] eff_cfg(input logic       smbus,
                                         input logic [7:0] stored,
                                         input logic [1:0] alt_pins,
                                         input logic       attach_pin);
    logic [7:0] v;
    v = stored;
    if (!smbus) begin
      v[bbcfg_pkg::VCONN_MSB:bbcfg_pkg::VCONN_LSB] = bbcfg_pkg::VCONN_I2C_FIXED;
      v[bbcfg_pkg::ALT_MSB:bbcfg_pkg::ALT_LSB]     = alt_pins;
      v[bbcfg_pkg::FAIL_POS]                       = bbcfg_pkg::FAIL_I2C_FIXED;
      v[bbcfg_pkg::ATTACH_POS]                     = attach_pin;
    end
    return v;
  endfunction

  // Top bit of a power code means no power is needed
  function automatic logic vconn_not_needed(input logic [3:0] code);
    return code[3];
  endfunction

  // Reset release synchroniser
  logic [1:0] rst_pipe;
  logic [1:0] next_rst_pipe;
  logic       rst_sync_n;

  // Shift a one in behind the released reset
  always_comb begin
    next_rst_pipe = {rst_pipe[0], 1'b1};
  end

  // Assert at once, release two edges later
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= next_rst_pipe;
    end
  end

  assign rst_sync_n = rst_pipe[1];

  // Pin synchronisers: mode, two result straps, attach pin
  logic [3:0] pin_meta;
  logic [3:0] pin_sync;
  logic [3:0] next_pin_meta;
  logic [3:0] next_pin_sync;
  logic       mode_smbus;
  logic [1:0] alt_sync;
  logic       attach_sync;

  always_comb begin
    next_pin_meta = {smbus_mode_in, alt_mode_result_pins_in, billboard_attach_pin_in};
    next_pin_sync = pin_meta;
  end

  always_ff @(posedge sys_clk_in or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pin_meta <= 4'h0;
      pin_sync <= 4'h0;
    end else begin
      pin_meta <= next_pin_meta;
      pin_sync <= next_pin_sync;
    end
  end

  assign mode_smbus  = pin_sync[3];
  assign alt_sync    = pin_sync[2:1];
  assign attach_sync = pin_sync[0];

  // Stored register, written only in SMBus mode
  logic [7:0] cfg_q;
  logic [7:0] next_cfg_q;
  logic       wr_hit;
  logic       rd_hit;
  logic [7:0] cfg_eff;

  assign wr_hit  = reg_wr_in && (reg_addr_in == bbcfg_pkg::BBCFG_OFFSET);
  assign rd_hit  = reg_rd_in && (reg_addr_in == bbcfg_pkg::BBCFG_OFFSET);
  assign cfg_eff = eff_cfg(mode_smbus, cfg_q, alt_sync, attach_sync);

  always_comb begin
    next_cfg_q = cfg_q;
    if (wr_hit && mode_smbus) begin
      next_cfg_q = reg_wr_data_in;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cfg_q <= bbcfg_pkg::BBCFG_RESET;
    end else begin
      cfg_q <= next_cfg_q;
    end
  end

  // Read data and descriptor fields
  logic [7:0] next_rd_data;
  logic [3:0] next_vconn;
  logic       next_required;
  logic       next_reserved;
  logic [1:0] next_configured;
  logic       next_alt_ok;
  logic       next_failure;
  logic       next_connect;

  always_comb begin
    next_rd_data    = reg_rd_data_out;
    if (rd_hit) begin
      next_rd_data  = cfg_eff;
    end else if (reg_rd_in) begin
      next_rd_data  = bbcfg_pkg::BBCFG_RD_IDLE;
    end
    next_vconn      = cfg_eff[bbcfg_pkg::VCONN_MSB:bbcfg_pkg::VCONN_LSB];
    next_required   = !vconn_not_needed(next_vconn);
    next_reserved   = (next_vconn == bbcfg_pkg::VCONN_RESERVED);
    next_configured = cfg_eff[bbcfg_pkg::ALT_MSB:bbcfg_pkg::ALT_LSB];
    next_alt_ok     = (next_configured == bbcfg_pkg::ALT_CONFIGURED_OK);
    // Failure info masked when no power is needed
    next_failure    = cfg_eff[bbcfg_pkg::FAIL_POS] && !vconn_not_needed(next_vconn);
    next_connect    = cfg_eff[bbcfg_pkg::ATTACH_POS];
  end

  always_ff @(posedge sys_clk_in or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      reg_rd_data_out         <= bbcfg_pkg::BBCFG_RD_IDLE;
      desc_vconn_power_out    <= bbcfg_pkg::VCONN_I2C_FIXED; // Matches the flags below
      desc_vconn_required_out <= 1'b0;
      desc_vconn_reserved_out <= 1'b0;
      desc_configured_out     <= 2'h0;
      desc_alt_mode_ok_out    <= 1'b0;
      desc_failure_info_out   <= 1'b0;
      billboard_connect_out   <= 1'b0;
    end else begin
      reg_rd_data_out         <= next_rd_data;
      desc_vconn_power_out    <= next_vconn;
      desc_vconn_required_out <= next_required;
      desc_vconn_reserved_out <= next_reserved;
      desc_configured_out     <= next_configured;
      desc_alt_mode_ok_out    <= next_alt_ok;
      desc_failure_info_out   <= next_failure;
      billboard_connect_out   <= next_connect;
    end
  end

  // Checks
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_sync_n);

  chk_vconn_write_back: assert property (
    (wr_hit && mode_smbus) ##1 !wr_hit ##1 (rd_hit && !reg_wr_in && mode_smbus)
      |=> reg_rd_data_out[7:4] == $past(reg_wr_data_in[7:4], 3))
    else $error("power field did not read back as written");

  chk_vconn_i2c_fixed: assert property (
    (rd_hit && !mode_smbus) |=> reg_rd_data_out[7:4] == 4'h8)
    else $error("power field not 1000b in I2C mode");

  chk_vconn_desc_follow: assert property (
    (wr_hit && mode_smbus) ##1 mode_smbus
      |=> desc_vconn_power_out == $past(reg_wr_data_in[7:4], 2))
    else $error("descriptor power field not updated");

  chk_vconn_code_flags: assert property (
    desc_vconn_required_out == !desc_vconn_power_out[3] &&
    desc_vconn_reserved_out == (desc_vconn_power_out == 4'h7))
    else $error("power code flags wrong");

  chk_alt_smbus_write: assert property (
    (wr_hit && mode_smbus) ##1 mode_smbus
      |=> desc_configured_out == $past(reg_wr_data_in[3:2], 2))
    else $error("result field not driven from write");

  chk_alt_i2c_pins: assert property (
    $past(!mode_smbus) |-> desc_configured_out == $past(alt_sync))
    else $error("result field not following straps");

  chk_alt_ok_code: assert property (
    desc_alt_mode_ok_out == (desc_configured_out == 2'h3))
    else $error("configured flag wrong");

  chk_failure_masked: assert property (
    desc_vconn_power_out[3] |-> !desc_failure_info_out)
    else $error("failure info shown with no power need");

  chk_failure_smbus: assert property (
    ($past(mode_smbus) && !$past(cfg_q[7]))
      |-> desc_failure_info_out == $past(cfg_q[1]))
    else $error("failure info not presented");

  chk_failure_i2c_zero: assert property (
    (rd_hit && !mode_smbus) |=> !reg_rd_data_out[1] && !desc_failure_info_out)
    else $error("failure info not zero in I2C mode");

  chk_attach_i2c_pin: assert property (
    $past(!mode_smbus) |-> billboard_connect_out == $past(attach_sync))
    else $error("attach bit not following pin");

  chk_attach_smbus_write: assert property (
    (wr_hit && mode_smbus) ##1 mode_smbus
      |=> billboard_connect_out == $past(reg_wr_data_in[0], 2))
    else $error("attach bit not driven from write");

  chk_i2c_write_ignored: assert property (
    (wr_hit && !mode_smbus) |=> $stable(cfg_q))
    else $error("write accepted in I2C mode");

  // Register port checks
  chk_smbus_write_store: assert property (
    (wr_hit && mode_smbus) |=> cfg_q == $past(reg_wr_data_in))
    else $error("write not stored in SMBus mode");

  chk_rd_data_holds: assert property (
    !reg_rd_in |=> $stable(reg_rd_data_out))
    else $error("read data changed without a read");

  chk_unmapped_read_zero: assert property (
    (reg_rd_in && !rd_hit) |=> reg_rd_data_out == 8'h00)
    else $error("unmapped read not zero");

  chk_unmapped_write_ignored: assert property (
    (reg_wr_in && !wr_hit) |=> $stable(cfg_q))
    else $error("unmapped write changed the register");

  // Descriptor checks, and I2C read-back of result and attach bits
  chk_vconn_i2c_desc: assert property (
    !mode_smbus |=> desc_vconn_power_out == 4'h8)
    else $error("descriptor power field not 1000b in I2C mode");

  chk_vconn_smbus_desc: assert property (
    mode_smbus |=> desc_vconn_power_out == $past(cfg_q[7:4]))
    else $error("descriptor power field not the stored value");

  chk_reserved_needs_power: assert property (
    desc_vconn_reserved_out |-> desc_vconn_required_out)
    else $error("reserved power code flagged as no need");

  chk_alt_smbus_desc: assert property (
    mode_smbus |=> desc_configured_out == $past(cfg_q[3:2]))
    else $error("descriptor result not the stored value");

  chk_alt_i2c_read: assert property (
    (rd_hit && !mode_smbus) |=> reg_rd_data_out[3:2] == $past(alt_sync))
    else $error("read result not following straps");

  chk_alt_ok_smbus: assert property (
    (mode_smbus && cfg_q[3:2] == 2'h3) |=> desc_alt_mode_ok_out)
    else $error("configured flag missing for code 11b");

  chk_failure_i2c_desc: assert property (
    !mode_smbus |=> !desc_failure_info_out)
    else $error("descriptor failure info not zero in I2C mode");

  chk_attach_i2c_read: assert property (
    (rd_hit && !mode_smbus) |=> reg_rd_data_out[0] == $past(attach_sync))
    else $error("read attach bit not following pin");

  chk_attach_smbus_desc: assert property (
    mode_smbus |=> billboard_connect_out == $past(cfg_q[0]))
    else $error("connect output not the stored value");

  // Main scenarios
  cov_smbus_write: cover property (wr_hit && mode_smbus ##2 rd_hit);
  cov_i2c_read:    cover property (rd_hit && !mode_smbus);
  cov_i2c_write:   cover property (wr_hit && !mode_smbus);
  cov_mode_switch: cover property (!mode_smbus ##1 mode_smbus);
  cov_masked_fail: cover property (cfg_q[7] && cfg_q[1] && mode_smbus);

endmodule
